// ===== include/conv_power_pkg.sv
package conv_power_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int SETTLE_MS = 10;
   localparam int SETTLE_CYCLES = (CLK_HZ / 1000) * SETTLE_MS;
   localparam int WAKE_CCLK = 6;
   localparam int CONV_CCLK = 18;
   localparam int CCLK_DIV = 2;
   localparam int NUM_PAIRS = 3;

   // ---------------------------------------------------------------
   // Control word bit positions
   // ---------------------------------------------------------------
   localparam int INTERLEAVE_BIT = 23;
   localparam int NAP_BIT = 22;
   localparam int BUSYPOL_BIT = 20;
   localparam int PD_LO_BIT = 13;
   localparam int EXT_CLOCK_BIT = 11;
   localparam logic [31:0] CONTROL_DEFAULT = 32'h0000_03ff;

   // ---------------------------------------------------------------
   // Resolution variants and result codes
   // ---------------------------------------------------------------
   localparam int RES_16 = 16;
   localparam int RES_14 = 14;
   localparam int RES_12 = 12;
   localparam logic [15:0] POS_FULL_16 = 16'h7fff;
   localparam logic [15:0] NEG_FULL_16 = 16'h8000;

   // ---------------------------------------------------------------
   // Host command register map (Avalon-MM word offsets in bytes)
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CONTROL = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_RESULT = 4'hc;
   localparam int CMD_START = 0;
   localparam int CMD_RESET = 3;
   localparam int CMD_STANDBY = 4;
   localparam int CMD_PARTIAL = 5;

   typedef enum logic [3:0] {
      PH_SAMPLE = 4'b0001,
      PH_WAKE = 4'b0010,
      PH_CONVERT = 4'b0100,
      PH_DOZE = 4'b1000
   } pair_phase_t;

   function automatic logic [15:0] format_result(input logic [15:0] raw, input int res);
      logic [15:0] mask;
      mask = 16'hffff >> (16 - res);
      format_result = raw & mask;
   endfunction : format_result
endpackage : conv_power_pkg

// ===== include/conv_link_if.sv
`timescale 1ns/100ps
interface conv_link_if;
   logic [2:0] pair_convert_start;
   logic reset_pin;
   logic standby_n;
   logic conv_clock;
   logic control_load;
   logic [31:0] control_word;
   logic software_mode_select;
   logic busy;
   logic [15:0] parallel_data_lines;
   logic [1:0] result_select;
   modport device (
      input pair_convert_start, reset_pin, standby_n, conv_clock, control_load,
      input control_word, software_mode_select, result_select,
      output busy, parallel_data_lines
   );
   modport host (
      output pair_convert_start, reset_pin, standby_n, conv_clock, control_load,
      output control_word, software_mode_select, result_select,
      input busy, parallel_data_lines
   );
endinterface : conv_link_if

// ===== src/conv_device.sv
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/100ps
module conv_device
   import conv_power_pkg::*;
#(
   parameter int RESOLUTION = RES_16,
   parameter int SETTLE = SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Link
   conv_link_if.device link,
   // Analog stand-in
   input wire logic [15:0] sample_value,
   // Power status
   output logic reference_on,
   output logic [2:0] pair_powered
);
   import conv_power_pkg::*;

   logic [31:0] control;
   pair_phase_t phase [NUM_PAIRS];
   logic [4:0] ccount [NUM_PAIRS];
   logic [2:0] partial_down;
   logic [2:0] partial_req;
   logic [2:0] start_q;
   logic clk_q;
   logic [31:0] settle_cnt;
   logic standby_q;
   logic [15:0] result [NUM_PAIRS];
   logic [15:0] data_out;
   logic notch;
   logic any_busy;

   wire cclk_rise = link.conv_clock & ~clk_q;
   wire sw_pd_ok = link.software_mode_select;
   wire [2:0] reg_pd = sw_pd_ok ? control[PD_LO_BIT +: NUM_PAIRS] : 3'h0;
   wire interleave_mode = control[INTERLEAVE_BIT] & control[EXT_CLOCK_BIT];
   wire master_reset = ~reset_n | link.reset_pin;

   // ---------------------------------------------------------------
   // Control word
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         control <= CONTROL_DEFAULT;
      end else if (link.reset_pin) begin
         control <= CONTROL_DEFAULT;
      end else if (link.control_load) begin
         control <= link.control_word;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_q <= 1'b0;
         start_q <= 3'h0;
         standby_q <= 1'b1;
      end else begin
         clk_q <= link.conv_clock;
         start_q <= link.pair_convert_start;
         standby_q <= link.standby_n;
      end
   end

   // ---------------------------------------------------------------
   // Settle timer for standby release and pair power-up
   // ---------------------------------------------------------------
   logic [2:0] reg_pd_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         settle_cnt <= 32'h0;
         reg_pd_q <= 3'h0;
      end else begin
         reg_pd_q <= reg_pd;
         if ((link.standby_n & ~standby_q) | |(reg_pd_q & ~reg_pd)) begin
            settle_cnt <= 32'(SETTLE);
         end else if (settle_cnt != 32'h0) begin
            settle_cnt <= settle_cnt - 32'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Per pair phase machines
   // ---------------------------------------------------------------
   for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
      wire start_rise = link.pair_convert_start[p] & ~start_q[p];
      wire may_start = link.standby_n & (settle_cnt == 32'h0) & ~reg_pd[p] & ~partial_down[p];
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            phase[p] <= PH_SAMPLE;
            ccount[p] <= 5'h0;
            partial_req[p] <= 1'b0;
            partial_down[p] <= 1'b0;
            result[p] <= 16'h0;
         end else if (link.reset_pin) begin
            phase[p] <= PH_SAMPLE;
            ccount[p] <= 5'h0;
            partial_req[p] <= 1'b0;
            partial_down[p] <= 1'b0;
         end else if (!link.standby_n || reg_pd[p]) begin
            phase[p] <= PH_SAMPLE;
            ccount[p] <= 5'h0;
         end else begin
            case (phase[p])
               PH_SAMPLE, PH_DOZE: begin
                  if (start_rise && may_start) begin
                     phase[p] <= control[NAP_BIT] ? PH_WAKE : PH_CONVERT;
                     ccount[p] <= 5'h0;
                  end
               end
               PH_WAKE: begin
                  if (cclk_rise) begin
                     if (ccount[p] == 5'(WAKE_CCLK - 1)) begin
                        phase[p] <= PH_CONVERT;
                        ccount[p] <= 5'h0;
                     end else begin
                        ccount[p] <= ccount[p] + 5'h1;
                     end
                  end
               end
               PH_CONVERT: begin
                  if (!link.pair_convert_start[p]) begin
                     partial_req[p] <= 1'b1;
                  end
                  if (cclk_rise) begin
                     if (ccount[p] == 5'(CONV_CCLK - 1)) begin
                        result[p] <= format_result(sample_value, RESOLUTION);
                        ccount[p] <= 5'h0;
                        partial_down[p] <= partial_req[p] | ~link.pair_convert_start[p];
                        partial_req[p] <= 1'b0;
                        phase[p] <= control[NAP_BIT] ? PH_DOZE : PH_SAMPLE;
                     end else begin
                        ccount[p] <= ccount[p] + 5'h1;
                     end
                  end
               end
               default: phase[p] <= PH_SAMPLE;
            endcase
         end
      end
      assign pair_powered[p] = link.standby_n & ~reg_pd[p] & ~partial_down[p];
   end

   // Reference survives partial and doze; only standby or full pair power-down stops it
   assign reference_on = link.standby_n & (reg_pd != 3'h7);

   // ---------------------------------------------------------------
   // Busy and readout
   // ---------------------------------------------------------------
   always_comb begin
      any_busy = 1'b0;
      for (int i = 0; i < NUM_PAIRS; i++) begin
         any_busy = any_busy | (phase[i] == PH_CONVERT) | (phase[i] == PH_WAKE);
      end
   end

   // In interleave mode a pair finishing while others convert drops busy for one conversion clock
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         notch <= 1'b0;
      end else if (master_reset) begin
         notch <= 1'b0;
      end else if (cclk_rise) begin
         notch <= 1'b0;
         for (int i = 0; i < NUM_PAIRS; i++) begin
            if (interleave_mode && phase[i] == PH_CONVERT && ccount[i] == 5'(CONV_CCLK - 1)) begin
               notch <= 1'b1;
            end
         end
      end
   end

   assign link.busy = (any_busy & ~notch) ^ control[BUSYPOL_BIT];

   // Interface stays alive during standby so results remain readable
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_out <= 16'h0;
      end else begin
         data_out <= (link.result_select < 2'(NUM_PAIRS)) ?
                     result[link.result_select] : 16'h0;
      end
   end
   assign link.parallel_data_lines = data_out;
endmodule : conv_device

// ===== src/conv_host.sv
`timescale 1ns/100ps
module conv_host
   import conv_power_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Link
   conv_link_if.host link
);
   import conv_power_pkg::*;

   logic [31:0] control;
   logic [2:0] starts;
   logic rst_pin;
   logic standby_out;
   logic [2:0] pend;
   logic cclk;
   logic [$clog2(CCLK_DIV)-1:0] div;
   logic load;
   logic [31:0] wait_cnt;
   logic [2:0] guard;
   logic [31:0] rdata;
   logic rvalid;

   wire access = read | write;
   // One wait state: the answer comes at the second edge
   assign waitrequest = access & ~rvalid;
   assign readdata = rdata;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid <= 1'b0;
      end else begin
         rvalid <= access & ~rvalid;
      end
   end

   // ---------------------------------------------------------------
   // Conversion clock, made here
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div <= '0;
         cclk <= 1'b0;
      end else begin
         div <= div + 1'b1;
         if (div == '0) begin
            cclk <= ~cclk;
         end
      end
   end

   // ---------------------------------------------------------------
   // Commands
   // ---------------------------------------------------------------
   wire wr_ok = write & rvalid;
   wire [2:0] req = writedata[CMD_START +: NUM_PAIRS];
   // A start is refused while a reset or settle delay runs, or in standby
   wire start_ok = (wait_cnt == 32'h0) & ~writedata[CMD_RESET] & standby_out;
   wire ext_clock_need = writedata[EXT_CLOCK_BIT] | writedata[INTERLEAVE_BIT];
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         control <= CONTROL_DEFAULT;
         load <= 1'b0;
         starts <= 3'h0;
         pend <= 3'h0;
         rst_pin <= 1'b0;
         standby_out <= 1'b1;
         wait_cnt <= 32'h0;
      end else begin
         load <= 1'b0;
         rst_pin <= 1'b0;
         if (wait_cnt != 32'h0) begin
            wait_cnt <= wait_cnt - 32'h1;
         end
         if (wr_ok && address == REG_CONTROL) begin
            control <= writedata;
            control[EXT_CLOCK_BIT] <= ext_clock_need;
            load <= 1'b1;
            if (|(control[PD_LO_BIT +: NUM_PAIRS] & ~writedata[PD_LO_BIT +: NUM_PAIRS])) begin
               wait_cnt <= 32'(SETTLE);
            end
         end else if (wr_ok && address == REG_CMD) begin
            if (writedata[CMD_RESET]) begin
               rst_pin <= 1'b1;
               control <= CONTROL_DEFAULT;
               wait_cnt <= 32'(WAKE_CCLK * CCLK_DIV * 2);
            end
            if (writedata[CMD_STANDBY] && !standby_out) begin
               wait_cnt <= 32'(SETTLE);
            end
            standby_out <= writedata[CMD_STANDBY];
            if (writedata[CMD_PARTIAL]) begin
               // Dropping a line mid-conversion parks that pair
               starts <= starts & ~req;
               pend <= pend & ~req;
            end else if (start_ok) begin
               pend <= req;
            end else if (writedata[CMD_RESET]) begin
               pend <= 3'h0;
            end
         end else if (cclk) begin
            // Lines stay up through the conversion; a low line would mean power-down
            starts <= pend;
         end
      end
   end

   assign link.pair_convert_start = starts;
   assign link.reset_pin = rst_pin;
   assign link.standby_n = standby_out;
   assign link.conv_clock = cclk;
   assign link.control_load = load;
   assign link.control_word = control;
   assign link.software_mode_select = 1'b1;
   assign link.result_select = address[1:0];

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 32'h0;
      end else if (read && !rvalid) begin
         case (address)
            REG_CONTROL: rdata <= control;
            REG_STATUS: rdata <= {30'h0, wait_cnt != 32'h0, link.busy};
            REG_RESULT: rdata <= {16'h0, link.parallel_data_lines};
            default: rdata <= 32'h0;
         endcase
      end
   end
endmodule : conv_host

// ===== test/conv_link_sva.sv
`timescale 1ns/100ps
module conv_link_sva
   import conv_power_pkg::*;
#(
   parameter int RESOLUTION = RES_16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Link
   input wire logic reset_pin,
   input wire logic standby_n,
   input wire logic control_load,
   input wire logic [31:0] control_word,
   input wire logic software_mode_select,
   input wire logic busy,
   input wire logic [15:0] parallel_data_lines,
   // Power status
   input wire logic reference_on,
   input wire logic [2:0] pair_powered
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // ----------
   // Link rules
   // ----------
   property p_top_zero;
      (parallel_data_lines >> RESOLUTION) == 16'h0000;
   endproperty
   a_top_zero: assert property (p_top_zero) else $error("high data bits set");
   property p_standby_off;
      !standby_n |-> pair_powered == 3'b000 && !reference_on;
   endproperty
   a_standby_off: assert property (p_standby_off) else $error("powered in standby");
   property p_ref_on;
      standby_n && pair_powered != 3'b000 |-> reference_on;
   endproperty
   a_ref_on: assert property (p_ref_on) else $error("reference off");
   property p_pd_bit;
      control_load && software_mode_select && standby_n && control_word[PD_LO_BIT]
         |-> ##[1:3] !pair_powered[0];
   endproperty
   a_pd_bit: assert property (p_pd_bit) else $error("pair not powered down");
   property p_all_down;
      control_load && standby_n && control_word[15:13] == 3'b111 |-> ##[1:3] !reference_on;
   endproperty
   a_all_down: assert property (p_all_down) else $error("reference still on");
   property p_reset_pin;
      reset_pin && standby_n |-> ##[1:3] (pair_powered == 3'b111 && !busy);
   endproperty
   a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");
   property p_first_idle;
      $rose(reset_n) |-> !busy;
   endproperty
   a_first_idle: assert property (p_first_idle) else $error("busy not idle");
   property p_settle;
      $rose(standby_n) |=> $stable(busy) [*8];
   endproperty
   a_settle: assert property (p_settle) else $error("start during settle");
   // A pair comes back only through reset, register update or standby release
   property p_wake;
      $rose(pair_powered[0]) |-> $past(reset_pin) || $past(reset_pin, 2)
         || $past(control_load) || $past(control_load, 2) || !$past(standby_n);
   endproperty
   a_wake: assert property (p_wake) else $error("pair woke alone");
   property p_interleave_clock;
      control_load && control_word[INTERLEAVE_BIT] |-> control_word[EXT_CLOCK_BIT];
   endproperty
   a_interleave_clock: assert property (p_interleave_clock) else $error("interleave without external clock");
endmodule : conv_link_sva

// ===== test/adc_conversion_power_control_tb.sv
`timescale 1ns/100ps
module adc_conversion_power_control_tb;
   import conv_power_pkg::*;
   // Short settle so standby and power-down fit the run
   localparam int SETTLE_SIM = 20;
   logic clk;
   logic reset_n;
   logic [3:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic waitrequest;
   logic [15:0] sample_value;
   logic reference_on;
   logic [2:0] pair_powered;
   logic [31:0] rd;
   int error_cnt;
   int checks;
   conv_link_if link();
   conv_device #(.RESOLUTION(RES_14), .SETTLE(SETTLE_SIM)) conv_device_inst (
      .clk(clk), .reset_n(reset_n), .link(link), .sample_value(sample_value),
      .reference_on(reference_on), .pair_powered(pair_powered));
   conv_host #(.SETTLE(SETTLE_SIM)) conv_host_inst (
      .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .link(link));
   conv_link_sva #(.RESOLUTION(RES_14)) conv_link_sva_inst (
      .clk(clk), .reset_n(reset_n), .reset_pin(link.reset_pin), .standby_n(link.standby_n),
      .control_load(link.control_load), .control_word(link.control_word),
      .software_mode_select(link.software_mode_select), .busy(link.busy),
      .parallel_data_lines(link.parallel_data_lines), .reference_on(reference_on),
      .pair_powered(pair_powered));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ----------
   // Bus and check tasks
   // ----------
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Waitrequest and read data are taken at the rising edge that ends the wait
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= d;
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      check("bus answer", 32'(n < 50), 32'h1);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask : bus
   task wait_busy(input logic lvl);
      int n;
      n = 0;
      @(negedge clk);
      while (link.busy !== lvl && n < 300) begin
         @(negedge clk);
         n++;
      end
      check("busy level", 32'(n < 300), 32'h1);
   endtask : wait_busy
   task pause(input int k);
      repeat (k) @(posedge clk);
      @(negedge clk);
   endtask : pause
   task power(input logic [2:0] pairs, input logic ref_on);
      check("pair power", 32'(pair_powered), 32'(pairs));
      check("reference", 32'(reference_on), 32'(ref_on));
   endtask : power
   task convert(input logic [15:0] raw);
      @(posedge clk);
      sample_value <= raw;
      bus(1'b1, REG_CMD, 32'h11);
      wait_busy(1'b1);
      wait_busy(1'b0);
      bus(1'b1, REG_CMD, 32'h10);
   endtask : convert
   // ----------
   // Scenarios
   // ----------
   task t_reset;
      power(3'b111, 1'b1);
      check("busy idle", 32'(link.busy), 32'h0);
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped", rd, 32'h0);
      bus(1'b0, REG_STATUS, 32'h0);
      check("status", rd, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task t_format;
      logic [15:0] codes [3];
      codes = '{16'h1fff, 16'h2000, 16'hffff};
      bus(1'b1, REG_CONTROL, CONTROL_DEFAULT);
      foreach (codes[i]) begin
         convert(codes[i]);
         bus(1'b0, REG_RESULT, 32'h0);
         check("result", rd, {18'h0, codes[i][13:0]});
      end
      $display("test format done");
   endtask : t_format
   task t_partial;
      bus(1'b1, REG_CMD, 32'h11);
      wait_busy(1'b1);
      bus(1'b1, REG_CMD, 32'h31);
      wait_busy(1'b0);
      pause(2);
      power(3'b110, 1'b1);
      bus(1'b1, REG_CMD, 32'h18);
      bus(1'b1, REG_CMD, 32'h10);
      pause(2);
      power(3'b111, 1'b1);
      pause(WAKE_CCLK * CCLK_DIV * 2);
      convert(16'h0123);
      $display("test partial done");
   endtask : t_partial
   task t_power_down;
      bus(1'b1, REG_CONTROL, 32'h0000_23ff);
      pause(3);
      power(3'b110, 1'b1);
      bus(1'b1, REG_CONTROL, 32'h0000_e3ff);
      pause(3);
      power(3'b000, 1'b0);
      bus(1'b1, REG_CONTROL, CONTROL_DEFAULT);
      pause(3);
      power(3'b111, 1'b1);
      $display("test power down done");
   endtask : t_power_down
   task t_standby;
      bus(1'b1, REG_CONTROL, 32'h0010_03ff);
      pause(3);
      check("busy idle", 32'(link.busy), 32'h1);
      bus(1'b1, REG_CMD, 32'h00);
      pause(2);
      power(3'b000, 1'b0);
      bus(1'b0, REG_RESULT, 32'h0);
      check("standby read", rd, 32'h0123);
      bus(1'b1, REG_CMD, 32'h10);
      bus(1'b0, REG_STATUS, 32'h0);
      check("settling", 32'(rd[1]), 32'h1);
      bus(1'b1, REG_CMD, 32'h11);
      pause(2);
      check("start refused", 32'(link.busy), 32'h1);
      bus(1'b1, REG_CMD, 32'h10);
      pause(SETTLE_SIM);
      check("control kept", 32'(link.busy), 32'h1);
      bus(1'b1, REG_CMD, 32'h18);
      pause(3);
      check("busy default", 32'(link.busy), 32'h0);
      bus(1'b1, REG_CMD, 32'h10);
      $display("test standby done");
   endtask : t_standby
   task t_doze;
      int n;
      n = 0;
      pause(WAKE_CCLK * CCLK_DIV * 2);
      bus(1'b1, REG_CONTROL, 32'h0040_03ff);
      @(posedge clk);
      sample_value <= 16'h0abc;
      bus(1'b1, REG_CMD, 32'h11);
      wait_busy(1'b1);
      while (link.busy === 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      // Wake plus conversion, with up to one conversion clock of phase slack
      check("doze span", 32'(n > (WAKE_CCLK + CONV_CCLK - 1) * CCLK_DIV * 2), 32'h1);
      check("doze span max", 32'(n <= (WAKE_CCLK + CONV_CCLK) * CCLK_DIV * 2), 32'h1);
      bus(1'b0, REG_RESULT, 32'h0);
      check("doze result", rd, 32'h0000_0abc);
      bus(1'b1, REG_CMD, 32'h10);
      $display("test doze done");
   endtask : t_doze
   task t_interleave;
      int n;
      n = 0;
      bus(1'b1, REG_CONTROL, 32'h0080_03ff);
      bus(1'b0, REG_CONTROL, 32'h0);
      check("external clock forced", rd, 32'h0080_0bff);
      bus(1'b1, REG_CMD, 32'h11);
      wait_busy(1'b1);
      pause(CCLK_DIV * 8);
      bus(1'b1, REG_CMD, 32'h13);
      wait_busy(1'b0);
      while (link.busy !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      check("notch length", 32'(n), 32'(CCLK_DIV * 2));
      wait_busy(1'b0);
      bus(1'b1, REG_CMD, 32'h10);
      bus(1'b1, REG_CONTROL, CONTROL_DEFAULT);
      $display("test interleave done");
   endtask : t_interleave
   // ----------
   // Main sequence
   // ----------
   task end_of_test;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   initial begin
      reset_n = 1'b0;
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      sample_value = 16'h0;
      error_cnt = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      pause(1);
      t_reset();
      t_format();
      t_partial();
      t_power_down();
      t_standby();
      t_doze();
      t_interleave();
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
endmodule : adc_conversion_power_control_tb
